// [hdl/prbs_tester_error_insert_counters.sv]
// Added by the designer: the APB register port.
`timescale 1ns/1ns
module prbs_tester_error_insert_counters #(
    parameter int PAT_W = 32,
    parameter int ERR_W = 24,
    parameter int BIT_W = 32
) (
    input wire logic clk_sys_in, // system clock, 100 MHz
    input wire logic rst_in, // synchronous reset, active high
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction, 1 = write
    input wire logic [11:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error on unmapped address
    input wire logic tx_bit_en_in, // one transmit bit opportunity
    input wire logic ext_error_insert_in, // external manual error input
    output logic tx_data_out, // transmit bit after insertion
    input wire logic rx_bit_en_in, // one received bit present
    input wire logic rx_data_in, // received bit
    input wire logic rx_out_of_sync_in, // receive generator not in sync
    input wire logic counter_update_request_in, // global or port update request
    output logic status_irq_out // interrupt request, active high
);
    localparam logic [ERR_W-1:0] ERR_MAX = {ERR_W{1'b1}};
    localparam logic [BIT_W-1:0] BIT_MAX = {BIT_W{1'b1}};

    // register file state
    logic [15:0] control, next_control;
    logic [15:0] err_ctrl, next_err_ctrl;
    logic [15:0] irq_en, next_irq_en;
    logic [PAT_W-1:0] seed_pattern_word, next_seed_pattern_word;
    logic [3:0] latched, next_latched;
    logic [31:0] prdata, next_prdata;
    logic pready, next_pready;
    logic pslverr, next_pslverr;
    logic irq, next_irq;

    // transmit state
    tester_pkg::rate_state_e rate_state, next_rate_state;
    logic [2:0] rate_active, next_rate_active;
    logic [tester_pkg::RATE_CNT_W-1:0] rate_cnt, next_rate_cnt;
    logic trig_prev, next_trig_prev;
    logic single_pending, next_single_pending;
    logic [PAT_W-1:0] tx_pat, next_tx_pat;
    logic tx_data, next_tx_data;

    // receive state
    logic [PAT_W-1:0] rx_ref, next_rx_ref;
    logic [ERR_W-1:0] err_cnt, next_err_cnt;
    logic [BIT_W-1:0] bit_cnt, next_bit_cnt;
    logic [ERR_W-1:0] err_snap, next_err_snap;
    logic [BIT_W-1:0] bit_snap, next_bit_snap;
    logic upd_prev, next_upd_prev;
    logic update_done, next_update_done;
    logic nonzero, next_nonzero;
    logic pattern_out_of_sync, next_oos;

    // bus decode
    logic [9:0] idx;
    logic setup_phase;
    logic wr_access;
    logic mapped;
    logic wr_err_ctrl;
    logic wr_seed;

    assign idx = paddr_in[11:2];
    assign setup_phase = psel_in && !penable_in;
    // pready is only ever high in the access phase, so this is the completing edge
    assign wr_access = psel_in && penable_in && pready && pwrite_in;

    always_comb begin
        mapped = 1'b1;
        if (paddr_in[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else if (idx == tester_pkg::IDX_CONTROL) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_SEED_LOW) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_SEED_HIGH) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_ERR_CTRL) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_STATUS) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_LATCHED) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_IRQ_EN) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_ERRCNT_LOW) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_ERRCNT_HIGH) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_BITS_LOW) begin
            mapped = 1'b1;
        end else if (idx == tester_pkg::IDX_BITS_HIGH) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign wr_err_ctrl = wr_access && mapped && (idx == tester_pkg::IDX_ERR_CTRL);
    assign wr_seed = wr_access && mapped &&
        ((idx == tester_pkg::IDX_SEED_LOW) || (idx == tester_pkg::IDX_SEED_HIGH));

    // receive-side events
    logic bit_error;
    logic bit_count_en;
    logic upd_req;
    logic upd_rise;

    assign bit_count_en = rx_bit_en_in && !rx_out_of_sync_in;
    assign bit_error = bit_count_en && (rx_data_in != rx_ref[PAT_W-1]);
    assign upd_req = control[tester_pkg::CTL_SOURCE_SEL] ?
        counter_update_request_in : control[tester_pkg::CTL_LOCAL_REQ];
    assign upd_rise = upd_req && !upd_prev;

    always_comb begin
        next_rx_ref = rx_ref;
        next_err_cnt = err_cnt;
        next_bit_cnt = bit_cnt;
        next_err_snap = err_snap;
        next_bit_snap = bit_snap;
        next_upd_prev = upd_req;
        // while out of sync the reference waits at the seed so the first bit meets its MSB
        if (rx_out_of_sync_in) begin
            next_rx_ref = seed_pattern_word;
        end else if (rx_bit_en_in) begin
            next_rx_ref = {rx_ref[PAT_W-2:0], rx_ref[PAT_W-1]};
        end
        if (bit_error && (err_cnt != ERR_MAX)) begin
            next_err_cnt = err_cnt + 1'b1;
        end
        if (bit_count_en && (bit_cnt != BIT_MAX)) begin
            next_bit_cnt = bit_cnt + 1'b1;
        end
        if (upd_rise) begin
            // snapshot and restart; a bit arriving in this cycle starts the new interval
            next_err_snap = err_cnt;
            next_bit_snap = bit_cnt;
            next_err_cnt = bit_error ? {{(ERR_W-1){1'b0}}, 1'b1} : '0;
            next_bit_cnt = bit_count_en ? {{(BIT_W-1){1'b0}}, 1'b1} : '0;
        end
        // done sets on the same edge as the snapshot, drops as soon as the request falls
        next_update_done = upd_req && (update_done || upd_rise);
        next_nonzero = (next_err_cnt != '0);
        next_oos = rx_out_of_sync_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rx_ref <= '0;
            err_cnt <= '0;
            bit_cnt <= '0;
            err_snap <= '0;
            bit_snap <= '0;
            upd_prev <= 1'b0;
            update_done <= 1'b0;
            nonzero <= 1'b0;
            pattern_out_of_sync <= 1'b0;
        end else begin
            rx_ref <= next_rx_ref;
            err_cnt <= next_err_cnt;
            bit_cnt <= next_bit_cnt;
            err_snap <= next_err_snap;
            bit_snap <= next_bit_snap;
            upd_prev <= next_upd_prev;
            update_done <= next_update_done;
            nonzero <= next_nonzero;
            pattern_out_of_sync <= next_oos;
        end
    end

    // transmit error insertion
    logic [2:0] ctl_rate;
    logic trig_sel;
    logic trig_rise;
    logic single_en;
    logic rate_hit;
    logic single_hit;

    assign ctl_rate = err_ctrl[tester_pkg::ECTL_RATE_MSB:tester_pkg::ECTL_RATE_LSB];
    assign single_en = err_ctrl[tester_pkg::ECTL_SINGLE_EN];
    // a source switch from a low trigger to a high one shows up as a rise here
    assign trig_sel = err_ctrl[tester_pkg::ECTL_SOURCE_SEL] ?
        ext_error_insert_in : err_ctrl[tester_pkg::ECTL_TRIGGER];
    assign trig_rise = trig_sel && !trig_prev;
    assign rate_hit = tx_bit_en_in && (rate_state == tester_pkg::RATE_RUN) &&
        (rate_cnt == tester_pkg::decade_limit(rate_active));
    assign single_hit = tx_bit_en_in && single_pending && single_en;

    always_comb begin
        next_rate_state = rate_state;
        next_rate_active = rate_active;
        next_rate_cnt = rate_cnt;
        next_trig_prev = trig_sel;
        next_tx_pat = tx_pat;
        next_tx_data = tx_data;
        case (rate_state)
            tester_pkg::RATE_IDLE: begin
                if (wr_err_ctrl &&
                    (pwdata_in[tester_pkg::ECTL_RATE_MSB:tester_pkg::ECTL_RATE_LSB] != 3'h0)) begin
                    next_rate_state = tester_pkg::RATE_RUN;
                    next_rate_active =
                        pwdata_in[tester_pkg::ECTL_RATE_MSB:tester_pkg::ECTL_RATE_LSB];
                    next_rate_cnt = '0;
                end
            end
            tester_pkg::RATE_RUN: begin
                if (rate_hit) begin
                    // a rewrite mid-interval is picked up only here
                    next_rate_active = ctl_rate;
                    next_rate_cnt = '0;
                    if (ctl_rate == 3'h0) begin
                        next_rate_state = tester_pkg::RATE_IDLE;
                    end
                end else if (tx_bit_en_in) begin
                    next_rate_cnt = rate_cnt + 1'b1;
                end
            end
            default: begin
                next_rate_state = tester_pkg::RATE_IDLE;
            end
        endcase
        // one pending flag absorbs any number of rises before the next opportunity
        next_single_pending = single_en &&
            ((single_pending && !tx_bit_en_in) || trig_rise);
        if (wr_seed) begin
            // take the word as it stands after this write, not the stale half
            next_tx_pat = next_seed_pattern_word;
        end else if (tx_bit_en_in) begin
            next_tx_pat = {tx_pat[PAT_W-2:0], tx_pat[PAT_W-1]};
            next_tx_data = tx_pat[PAT_W-1] ^ (rate_hit || single_hit);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rate_state <= tester_pkg::RATE_IDLE;
            rate_active <= 3'h0;
            rate_cnt <= '0;
            trig_prev <= 1'b0;
            single_pending <= 1'b0;
            tx_pat <= '0;
            tx_data <= 1'b0;
        end else begin
            rate_state <= next_rate_state;
            rate_active <= next_rate_active;
            rate_cnt <= next_rate_cnt;
            trig_prev <= next_trig_prev;
            single_pending <= next_single_pending;
            tx_pat <= next_tx_pat;
            tx_data <= next_tx_data;
        end
    end

    // register file, latched status and interrupt
    logic [3:0] status_now;
    logic [3:0] latch_set;
    logic [3:0] irq_gate;

    assign status_now = {update_done, 1'b0, nonzero, pattern_out_of_sync};
    assign latch_set = {
        next_update_done && !update_done,
        bit_error,
        next_nonzero && !nonzero,
        next_oos != pattern_out_of_sync
    };
    assign irq_gate = control[tester_pkg::CTL_PORT_IRQ_EN] ? 4'hf :
        ~tester_pkg::PORT_GATED_MASK;

    always_comb begin
        next_control = control;
        next_err_ctrl = err_ctrl;
        next_irq_en = irq_en;
        next_seed_pattern_word = seed_pattern_word;
        next_latched = latched;
        next_prdata = prdata;
        next_pready = setup_phase;
        next_pslverr = setup_phase && !mapped;
        if (wr_access && mapped) begin
            if (idx == tester_pkg::IDX_CONTROL) begin
                next_control = pwdata_in[15:0] & tester_pkg::CTL_MASK;
            end else if (idx == tester_pkg::IDX_SEED_LOW) begin
                next_seed_pattern_word[15:0] = pwdata_in[15:0];
            end else if (idx == tester_pkg::IDX_SEED_HIGH) begin
                next_seed_pattern_word[PAT_W-1:16] = pwdata_in[15:0];
            end else if (idx == tester_pkg::IDX_ERR_CTRL) begin
                next_err_ctrl = pwdata_in[15:0] & tester_pkg::ECTL_MASK;
            end else if (idx == tester_pkg::IDX_LATCHED) begin
                next_latched = latched & ~pwdata_in[3:0];
            end else if (idx == tester_pkg::IDX_IRQ_EN) begin
                next_irq_en = {12'h000, pwdata_in[3:0]};
            end
        end
        // an event in the clearing cycle keeps its bit set
        next_latched = next_latched | latch_set;
        next_irq = |(next_latched & next_irq_en[3:0] & irq_gate);
        if (setup_phase) begin
            next_prdata = 32'h00000000;
            if (idx == tester_pkg::IDX_CONTROL) begin
                next_prdata[15:0] = control;
            end else if (idx == tester_pkg::IDX_SEED_LOW) begin
                next_prdata[15:0] = seed_pattern_word[15:0];
            end else if (idx == tester_pkg::IDX_SEED_HIGH) begin
                next_prdata[15:0] = seed_pattern_word[PAT_W-1:16];
            end else if (idx == tester_pkg::IDX_ERR_CTRL) begin
                next_prdata[15:0] = err_ctrl;
            end else if (idx == tester_pkg::IDX_STATUS) begin
                next_prdata[3:0] = status_now;
            end else if (idx == tester_pkg::IDX_LATCHED) begin
                next_prdata[3:0] = latched;
            end else if (idx == tester_pkg::IDX_IRQ_EN) begin
                next_prdata[15:0] = irq_en;
            end else if (idx == tester_pkg::IDX_ERRCNT_LOW) begin
                next_prdata[15:0] = err_snap[15:0];
            end else if (idx == tester_pkg::IDX_ERRCNT_HIGH) begin
                next_prdata[ERR_W-17:0] = err_snap[ERR_W-1:16];
            end else if (idx == tester_pkg::IDX_BITS_LOW) begin
                next_prdata[15:0] = bit_snap[15:0];
            end else if (idx == tester_pkg::IDX_BITS_HIGH) begin
                next_prdata[BIT_W-17:0] = bit_snap[BIT_W-1:16];
            end
            if (!mapped) begin
                next_prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            control <= tester_pkg::RST_CONTROL;
            err_ctrl <= tester_pkg::RST_ERR_CTRL;
            irq_en <= tester_pkg::RST_IRQ_EN;
            seed_pattern_word <= {2{tester_pkg::RST_SEED}};
            latched <= 4'h0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            control <= next_control;
            err_ctrl <= next_err_ctrl;
            irq_en <= next_irq_en;
            seed_pattern_word <= next_seed_pattern_word;
            latched <= next_latched;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end

    assign prdata_out = prdata;
    assign pready_out = pready;
    assign pslverr_out = pslverr;
    assign tx_data_out = tx_data;
    assign status_irq_out = irq;
endmodule : prbs_tester_error_insert_counters

// [common/tester_pkg.sv]
package tester_pkg;
    // registers are word indices; byte address is four times the index
    localparam logic [9:0] IDX_CONTROL = 10'h060;
    localparam logic [9:0] IDX_SEED_LOW = 10'h064;
    localparam logic [9:0] IDX_SEED_HIGH = 10'h066;
    localparam logic [9:0] IDX_ERR_CTRL = 10'h068;
    localparam logic [9:0] IDX_STATUS = 10'h06c;
    localparam logic [9:0] IDX_LATCHED = 10'h06e;
    localparam logic [9:0] IDX_IRQ_EN = 10'h070;
    localparam logic [9:0] IDX_ERRCNT_LOW = 10'h074;
    localparam logic [9:0] IDX_ERRCNT_HIGH = 10'h076;
    localparam logic [9:0] IDX_BITS_LOW = 10'h078;
    localparam logic [9:0] IDX_BITS_HIGH = 10'h07a;
    // error insertion control fields
    localparam int ECTL_SOURCE_SEL = 0;
    localparam int ECTL_TRIGGER = 1;
    localparam int ECTL_SINGLE_EN = 2;
    localparam int ECTL_RATE_LSB = 3;
    localparam int ECTL_RATE_MSB = 5;
    localparam logic [15:0] ECTL_MASK = 16'h003f;
    // control register fields
    localparam int CTL_LOCAL_REQ = 6;
    localparam int CTL_SOURCE_SEL = 7;
    localparam int CTL_PORT_IRQ_EN = 8;
    localparam logic [15:0] CTL_MASK = 16'h01c0;
    // status, latched status and interrupt enable bit positions
    localparam int STS_OUT_OF_SYNC = 0;
    localparam int STS_NONZERO = 1;
    localparam int STS_BIT_ERROR = 2;
    localparam int STS_UPDATE_DONE = 3;
    localparam logic [3:0] PORT_GATED_MASK = 4'h7;
    // reset values
    localparam logic [15:0] RST_CONTROL = 16'h0000;
    localparam logic [15:0] RST_ERR_CTRL = 16'h0000;
    localparam logic [15:0] RST_IRQ_EN = 16'h0000;
    localparam logic [15:0] RST_SEED = 16'h0000;
    localparam int RATE_CNT_W = 24;

    typedef enum logic [1:0] {
        RATE_IDLE = 2'b01,
        RATE_RUN = 2'b10
    } rate_state_e;

    // terminal count for one inverted bit in every 10^n
    function automatic logic [RATE_CNT_W-1:0] decade_limit(input logic [2:0] n);
        case (n)
            3'h1: decade_limit = 24'h000009;
            3'h2: decade_limit = 24'h000063;
            3'h3: decade_limit = 24'h0003e7;
            3'h4: decade_limit = 24'h00270f;
            3'h5: decade_limit = 24'h01869f;
            3'h6: decade_limit = 24'h0f423f;
            3'h7: decade_limit = 24'h98967f;
            default: decade_limit = 24'h000000;
        endcase
    endfunction : decade_limit
endpackage : tester_pkg

// [hdl/unused_placeholder_removed.sv]
`timescale 1ns/1ns

// [testbench/apb_host_model.sv]
`timescale 1ns/1ns
module apb_host_model (
    input wire logic clk_in, // system clock
    input wire logic pready_in, // slave ready
    input wire logic pslverr_in, // slave error
    input wire logic [31:0] prdata_in, // slave read data
    output logic psel_out, // select
    output logic penable_out, // enable
    output logic pwrite_out, // direction
    output logic [11:0] paddr_out, // byte address
    output logic [31:0] pwdata_out // write data
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h000;
        pwdata_out = 32'h0000_0000;
    end

    // call right after a rising edge; returns one idle edge after the access edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [15:0] d,
                        output logic [15:0] rd, output logic err, output logic ok);
        int n;
        n = 0;
        psel_out <= 1'b1;
        paddr_out <= a;
        pwrite_out <= w;
        pwdata_out <= {16'h0000, d};
        @(posedge clk_in);
        penable_out <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 40);
        ok = pready_in;
        rd = prdata_in[15:0];
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // the idle edge keeps a following call from re-raising psel in this time step
        @(posedge clk_in);
    endtask : xfer
endmodule : apb_host_model

// [testbench/prbs_tester_error_insert_counters_assertions.sv]
`timescale 1ns/1ns
module tester_checker #(
    parameter int PAT_W = 32,
    parameter int ERR_W = 24,
    parameter int BIT_W = 32
) (
    input wire logic clk_sys_in, // clock
    input wire logic rst_in, // reset
    input wire logic psel_in, // select
    input wire logic penable_in, // enable
    input wire logic pwrite_in, // direction
    input wire logic [11:0] paddr_in, // address
    input wire logic [31:0] prdata_out, // read data
    input wire logic pready_out, // ready
    input wire logic pslverr_out, // error
    input wire logic tx_bit_en_in, // tx strobe
    input wire logic tx_data_out, // tx bit
    input wire logic rx_out_of_sync_in // sync state
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence rd_s(idx);
        setup_s ##0 !pwrite_in && paddr_in == {idx, 2'b00};
    endsequence
    ready_next_a: assert property (setup_s |=> pready_out && penable_in)
        else $error("ready missing after setup");
    ready_access_a: assert property (pready_out |-> penable_in && $past(psel_in && !penable_in))
        else $error("ready outside access");
    unmapped_err_a: assert property (setup_s ##0 paddr_in[1:0] != 2'b00
        |=> pready_out && pslverr_out && prdata_out == 32'h0000_0000)
        else $error("unmapped access not refused");
    slverr_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    upper_zero_a: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
        else $error("upper read bits set");
    errhigh_narrow_a: assert property (rd_s(tester_pkg::IDX_ERRCNT_HIGH)
        |=> prdata_out[15:ERR_W-16] == '0) else $error("error count too wide");
    tx_hold_a: assert property (!tx_bit_en_in |=> $stable(tx_data_out))
        else $error("tx bit moved without strobe");
    // status lags its input by one edge, so only a steady input is compared
    sync_status_a: assert property (rd_s(tester_pkg::IDX_STATUS) ##0 !$past(rst_in)
        ##0 $stable(rx_out_of_sync_in) |=> prdata_out[0] == $past(rx_out_of_sync_in))
        else $error("sync status wrong");
endmodule : tester_checker

bind prbs_tester_error_insert_counters tester_checker #(
    .PAT_W(PAT_W),
    .ERR_W(ERR_W),
    .BIT_W(BIT_W)
) u_tester_checker (.clk_sys_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .prdata_out, .pready_out, .pslverr_out, .tx_bit_en_in, .tx_data_out, .rx_out_of_sync_in);

// [testbench/prbs_tester_error_insert_counters_tb.sv]
`timescale 1ns/1ns
module prbs_tester_error_insert_counters_tb;
    typedef struct packed {logic [9:0] idx; logic w; logic [15:0] d; logic [15:0] e;} row_s;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out, tx_data_out, status_irq_out;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, word;
    logic tx_bit_en_in = 1'b0, ext_error_insert_in = 1'b0, rx_bit_en_in = 1'b0;
    logic rx_data_in = 1'b0, rx_out_of_sync_in = 1'b0, counter_update_request_in = 1'b0;
    logic [15:0] rd;
    logic rerr;
    int errors = 0;
    int cmp_count = 0;
    int ones;
    row_s rows[12] = '{
        '{tester_pkg::IDX_ERR_CTRL, 1'b0, 16'h0000, 16'h0000},
        '{tester_pkg::IDX_IRQ_EN, 1'b0, 16'h0000, 16'h0000},
        '{tester_pkg::IDX_ERRCNT_LOW, 1'b0, 16'h0000, 16'h0000},
        '{tester_pkg::IDX_ERRCNT_HIGH, 1'b0, 16'h0000, 16'h0000},
        '{tester_pkg::IDX_BITS_LOW, 1'b0, 16'h0000, 16'h0000},
        '{tester_pkg::IDX_BITS_HIGH, 1'b0, 16'h0000, 16'h0000},
        '{tester_pkg::IDX_STATUS, 1'b0, 16'h0000, 16'h0000},
        '{tester_pkg::IDX_IRQ_EN, 1'b1, 16'hffff, 16'h000f},
        '{tester_pkg::IDX_IRQ_EN, 1'b1, 16'h0000, 16'h0000},
        '{tester_pkg::IDX_ERR_CTRL, 1'b1, 16'h0001, 16'h0001},
        '{tester_pkg::IDX_ERR_CTRL, 1'b1, 16'h0000, 16'h0000},
        '{tester_pkg::IDX_BITS_LOW, 1'b1, 16'h1234, 16'h0000}};

    always #5 clk_sys_in = ~clk_sys_in;

    prbs_tester_error_insert_counters u_prbs_tester_error_insert_counters (.clk_sys_in, .rst_in,
        .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .tx_bit_en_in, .ext_error_insert_in, .tx_data_out, .rx_bit_en_in,
        .rx_data_in, .rx_out_of_sync_in, .counter_update_request_in, .status_irq_out);
    apb_host_model u_apb_host_model (.clk_in(clk_sys_in), .pready_in(pready_out),
        .pslverr_in(pslverr_out), .prdata_in(prdata_out), .psel_out(psel_in),
        .penable_out(penable_in), .pwrite_out(pwrite_in), .paddr_out(paddr_in),
        .pwdata_out(pwdata_in));

    task automatic summarize();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic acc(input logic [11:0] a, input logic w, input logic [15:0] d);
        logic ok;
        u_apb_host_model.xfer(a, w, d, rd, rerr, ok);
        if (ok !== 1'b1) begin
            errors++;
            summarize();
        end
    endtask : acc

    task automatic reg_wr(input logic [9:0] idx, input logic [15:0] d);
        acc({idx, 2'b00}, 1'b1, d);
    endtask : reg_wr

    task automatic reg_chk(input string what, input logic [9:0] idx, input logic [15:0] e);
        acc({idx, 2'b00}, 1'b0, 16'h0000);
        chk(what, 32'(e), 32'(rd));
    endtask : reg_chk

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : idle

    // one strobe per cycle; word keeps the last 32 bits sent, first bit highest
    task automatic tx_bits(input int n);
        ones = 0;
        word = '0;
        tx_bit_en_in <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_in);
            if (i == n - 1)
                tx_bit_en_in <= 1'b0;
            #1;
            ones += int'(tx_data_out);
            word = {word[30:0], tx_data_out};
        end
        @(posedge clk_sys_in);
    endtask : tx_bits

    task automatic rx_feed(input logic [31:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            rx_bit_en_in <= 1'b1;
            rx_data_in <= bits[i];
            @(posedge clk_sys_in);
        end
        rx_bit_en_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask : rx_feed

    initial begin
        idle(12);
        rst_in <= 1'b0;
        idle(1);
        foreach (rows[i]) begin
            if (rows[i].w)
                reg_wr(rows[i].idx, rows[i].d);
            reg_chk("row", rows[i].idx, rows[i].e);
        end
        acc({tester_pkg::IDX_CONTROL, 2'b01}, 1'b0, 16'h0000);
        chk("slverr", 32'h1, 32'(rerr));
        reg_wr(tester_pkg::IDX_SEED_LOW, 16'h0f01);
        reg_wr(tester_pkg::IDX_SEED_HIGH, 16'ha5c3);
        tx_bits(32);
        chk("tx word", 32'ha5c3_0f01, word);
        rx_out_of_sync_in <= 1'b1;
        rx_feed(32'h0000_000f, 4);
        rx_out_of_sync_in <= 1'b0;
        idle(2);
        rx_feed(32'ha5c3_0f01 ^ 32'h8000_0101, 32);
        reg_wr(tester_pkg::IDX_CONTROL, 16'h0040);
        idle(3);
        reg_chk("err lo", tester_pkg::IDX_ERRCNT_LOW, 16'h0003);
        reg_chk("err hi", tester_pkg::IDX_ERRCNT_HIGH, 16'h0000);
        reg_chk("bits lo", tester_pkg::IDX_BITS_LOW, 16'h0020);
        reg_chk("bits hi", tester_pkg::IDX_BITS_HIGH, 16'h0000);
        reg_chk("status", tester_pkg::IDX_STATUS, 16'h0008);
        reg_chk("latched", tester_pkg::IDX_LATCHED, 16'h000f);
        reg_wr(tester_pkg::IDX_IRQ_EN, 16'h0004);
        idle(2);
        chk("irq gated", 32'h0, 32'(status_irq_out));
        reg_wr(tester_pkg::IDX_CONTROL, 16'h0100);
        idle(2);
        chk("irq port", 32'h1, 32'(status_irq_out));
        reg_chk("status", tester_pkg::IDX_STATUS, 16'h0000);
        reg_wr(tester_pkg::IDX_LATCHED, 16'h0004);
        reg_chk("latched", tester_pkg::IDX_LATCHED, 16'h000b);
        chk("irq clr", 32'h0, 32'(status_irq_out));
        reg_wr(tester_pkg::IDX_IRQ_EN, 16'h0008);
        reg_wr(tester_pkg::IDX_CONTROL, 16'h0000);
        idle(2);
        chk("irq done", 32'h1, 32'(status_irq_out));
        reg_wr(tester_pkg::IDX_LATCHED, 16'hffff);
        idle(2);
        chk("irq off", 32'h0, 32'(status_irq_out));
        reg_wr(tester_pkg::IDX_CONTROL, 16'h0080);
        counter_update_request_in <= 1'b1;
        idle(3);
        reg_chk("status", tester_pkg::IDX_STATUS, 16'h0008);
        reg_chk("err lo", tester_pkg::IDX_ERRCNT_LOW, 16'h0000);
        counter_update_request_in <= 1'b0;
        idle(3);
        reg_chk("status", tester_pkg::IDX_STATUS, 16'h0000);
        // all-zero pattern makes every one on the line an inserted error
        reg_wr(tester_pkg::IDX_SEED_LOW, 16'h0000);
        reg_wr(tester_pkg::IDX_SEED_HIGH, 16'h0000);
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0008);
        tx_bits(20);
        chk("rate 1", 32'd2, 32'(ones));
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0010);
        tx_bits(110);
        chk("rate swap", 32'd2, 32'(ones));
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0000);
        tx_bits(200);
        chk("rate stop", 32'd1, 32'(ones));
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0002);
        tx_bits(4);
        chk("single off", 32'd0, 32'(ones));
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0004);
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0006);
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0004);
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0006);
        tx_bits(4);
        chk("single", 32'd1, 32'(ones));
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0004);
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0005);
        ext_error_insert_in <= 1'b1;
        idle(2);
        ext_error_insert_in <= 1'b0;
        tx_bits(4);
        chk("ext", 32'd1, 32'(ones));
        reg_wr(tester_pkg::IDX_ERR_CTRL, 16'h0007);
        tx_bits(4);
        chk("ext only", 32'd0, 32'(ones));
        for (int n = 1; n < 8; n++) begin
            reg_wr(tester_pkg::IDX_ERR_CTRL, 16'(n << 3));
            reg_chk("rate code", tester_pkg::IDX_ERR_CTRL, 16'(n << 3));
        end
        summarize();
    end
endmodule : prbs_tester_error_insert_counters_tb
